// File: logic/mtc_pkg.sv
package mtc_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REPLY_W = 16;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_DATA = 12'h008;
	localparam int CTRL_RUNG = 0;
	localparam int CTRL_TO = 1;
	localparam int BIT_TO = 8;
	localparam int BIT_NR = 9;
	localparam int BIT_EW = 10;
	localparam int BIT_ER = 12;
	localparam int BIT_DN = 13;
	localparam int BIT_ST = 14;
	localparam int BIT_EN = 15;
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_BUSY = 8'h02;
	localparam logic [7:0] ERR_TIMEOUT = 8'h37;
	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
	typedef enum logic [1:0] {
		REPLY_WRITE = 2'b00,
		REPLY_READ = 2'b01,
		REPLY_ERROR = 2'b10
	} mtc_reply_t;
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_WAIT = 2'b01,
		PH_RUN = 2'b10,
		PH_DONE = 2'b11
	} mtc_phase_t;
	typedef struct packed {
		logic [ADDR_W-1:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [DATA_W-1:0] pwdata;
	} mtc_apb_req_t;
	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
	} mtc_apb_rsp_t;
	typedef struct packed {
		logic ack;
		logic nak;
		logic [7:0] nak_code;
		logic reply;
		mtc_reply_t reply_kind;
		logic [7:0] reply_code;
		logic [REPLY_W-1:0] reply_data;
	} mtc_net_evt_t;
	typedef struct packed {
		logic valid;
		logic [REPLY_W-1:0] data;
	} mtc_dest_wr_t;
endpackage

// File: logic/mtc_message_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module mtc_message_ctrl #(
	parameter int REPLY_DATA_W = 16
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire mtc_pkg::mtc_apb_req_t apb_req_in,
	output mtc_pkg::mtc_apb_rsp_t apb_rsp_out,
	input wire mtc_pkg::mtc_net_evt_t net_evt_in,
	input wire logic tx_buf_avail_in,
	input wire logic end_of_scan_in,
	input wire logic protocol_peer_in,
	output logic msg_send_out,
	output logic series_stat_out,
	output logic busy_out,
	output logic [15:0] status_word_out,
	output mtc_pkg::mtc_dest_wr_t dest_wr_out
);
	import mtc_pkg::*;

	// ************
	// Parameter check.
	// ************
	generate
		if (REPLY_DATA_W != REPLY_W) begin : g_bad_width
			$error("Reply data width must match the package width.");
		end
	endgenerate

	// ************
	// Register bus slave.
	// ************
	logic rung_reg, rung_next;
	logic rung_prev_reg;
	mtc_apb_rsp_t rsp_reg, rsp_next;
	logic [REPLY_W-1:0] data_reg, data_next;
	logic en_reg, st_reg, dn_reg, er_reg, ew_reg, nr_reg, to_reg;
	logic en_next, st_next, dn_next, er_next, ew_next, nr_next, to_next;
	logic [7:0] code_reg, code_next;
	logic [15:0] status_word;

	wire setup = apb_req_in.psel & ~apb_req_in.penable;
	wire access_done = apb_req_in.psel & apb_req_in.penable & rsp_reg.pready;
	wire sel_ctrl = apb_req_in.paddr == OFS_CTRL;
	wire sel_status = apb_req_in.paddr == OFS_STATUS;
	wire sel_data = apb_req_in.paddr == OFS_DATA;
	wire mapped = sel_ctrl | sel_status | sel_data;
	wire ctrl_wr = access_done & apb_req_in.pwrite & sel_ctrl;
	wire to_wr = ctrl_wr & apb_req_in.pwdata[CTRL_TO];
	wire [DATA_W-1:0] ctrl_word = {{(DATA_W-2){1'b0}}, to_reg, rung_reg};
	wire [DATA_W-1:0] rd_word = sel_ctrl ? ctrl_word :
		sel_status ? {16'h0000, status_word} :
		sel_data ? {{(DATA_W-REPLY_W){1'b0}}, data_reg} : ZERO_WORD;

	assign rung_next = ctrl_wr ? apb_req_in.pwdata[CTRL_RUNG] : rung_reg;
	assign rsp_next.pready = setup;
	assign rsp_next.pslverr = setup & ~mapped;
	assign rsp_next.prdata = (setup & ~apb_req_in.pwrite) ? rd_word : ZERO_WORD;

	// ************
	// Event latches and transaction phase.
	// ************
	mtc_phase_t phase_reg, phase_next;
	logic ack_lat_reg, nak_lat_reg, rep_lat_reg;
	logic ack_lat_next, nak_lat_next, rep_lat_next;
	logic [7:0] nak_code_reg, nak_code_next, rep_code_reg, rep_code_next;
	mtc_reply_t rep_kind_reg, rep_kind_next;
	logic [REPLY_W-1:0] rep_data_reg, rep_data_next;
	logic send_next, stat_next;
	mtc_dest_wr_t dest_next;

	wire rung_rise = rung_reg & ~rung_prev_reg;
	wire rung_fall = ~rung_reg & rung_prev_reg;
	wire to_kill = to_reg & st_reg;
	wire eos_take = end_of_scan_in & ~rung_rise & ~to_kill;
	wire flush = rung_rise | to_kill;
	wire ack_in = net_evt_in.ack & en_reg & (phase_reg == PH_WAIT);
	wire nak_in = net_evt_in.nak & en_reg & (phase_reg == PH_WAIT);
	wire rep_in = net_evt_in.reply & (phase_reg == PH_RUN);
	wire use_ack = eos_take & ack_lat_reg;
	wire use_nak = eos_take & nak_lat_reg & ~ack_lat_reg;
	wire use_rep = eos_take & rep_lat_reg & st_reg;
	wire finished = dn_reg | er_reg | to_reg;

	assign ack_lat_next = ~flush & ((ack_lat_reg & ~eos_take) | ack_in);
	assign nak_lat_next = ~flush & ((nak_lat_reg & ~eos_take) | nak_in);
	assign rep_lat_next = ~flush & ((rep_lat_reg & ~eos_take) | rep_in);
	assign nak_code_next = nak_in ? net_evt_in.nak_code : nak_code_reg;
	assign rep_code_next = rep_in ? net_evt_in.reply_code : rep_code_reg;
	assign rep_kind_next = rep_in ? net_evt_in.reply_kind : rep_kind_reg;
	assign rep_data_next = rep_in ? net_evt_in.reply_data : rep_data_reg;

	always_comb begin
		phase_next = phase_reg;
		case (phase_reg)
			PH_IDLE: begin
				if (rung_rise) begin
					phase_next = PH_WAIT;
				end
			end
			PH_WAIT: begin
				if (use_ack) begin
					phase_next = PH_RUN;
				end else if (use_nak) begin
					phase_next = PH_DONE;
				end
			end
			PH_RUN: begin
				if (to_kill | use_rep) begin
					phase_next = PH_DONE;
				end
			end
			PH_DONE: begin
				if (rung_rise) begin
					phase_next = PH_WAIT;
				end
			end
			default: begin
				phase_next = PH_IDLE;
			end
		endcase
	end

	// ************
	// Status flags.
	// ************
	always_comb begin
		en_next = en_reg;
		st_next = st_reg;
		dn_next = dn_reg;
		er_next = er_reg;
		ew_next = ew_reg;
		nr_next = nr_reg;
		to_next = to_reg;
		code_next = code_reg;
		data_next = data_reg;
		dest_next.valid = 1'b0;
		dest_next.data = rep_data_reg;
		if (rung_rise) begin
			ew_next = 1'b1;
			st_next = 1'b0;
			dn_next = 1'b0;
			nr_next = 1'b0;
			to_next = 1'b0;
			er_next = 1'b0;
			code_next = ERR_NONE;
		end else if (rung_fall) begin
			ew_next = 1'b0;
		end
		if (to_wr) begin
			to_next = 1'b1;
		end
		if (to_kill) begin
			er_next = 1'b1;
			st_next = 1'b0;
			code_next = ERR_TIMEOUT;
		end
		if (~en_reg & rung_reg & ew_reg & tx_buf_avail_in) begin
			en_next = 1'b1;
		end
		if (use_ack) begin
			ew_next = 1'b0;
			st_next = 1'b1;
		end else if (use_nak) begin
			ew_next = 1'b0;
			er_next = 1'b1;
			code_next = nak_code_reg;
			nr_next = protocol_peer_in & (nak_code_reg == ERR_BUSY);
		end else if (use_rep) begin
			st_next = 1'b0;
			case (rep_kind_reg)
				REPLY_WRITE: begin
					dn_next = 1'b1;
				end
				REPLY_READ: begin
					dn_next = 1'b1;
					dest_next.valid = 1'b1;
					data_next = rep_data_reg;
				end
				default: begin
					er_next = 1'b1;
					code_next = rep_code_reg;
				end
			endcase
		end
		if (end_of_scan_in & ~rung_reg & finished) begin
			en_next = 1'b0;
		end
	end

	assign send_next = en_next & ~en_reg;
	assign stat_next = (series_stat_out | send_next) & ~ack_in;
	assign status_word = {en_reg, st_reg, dn_reg, er_reg, 1'b0, ew_reg, nr_reg, to_reg,
		code_reg};

	// ************
	// Flip-flops.
	// ************
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rung_reg <= 1'b0;
			rung_prev_reg <= 1'b0;
			rsp_reg <= '0;
			data_reg <= '0;
			{en_reg, st_reg, dn_reg, er_reg, ew_reg, nr_reg, to_reg} <= 7'h00;
			code_reg <= ERR_NONE;
			phase_reg <= PH_IDLE;
			{ack_lat_reg, nak_lat_reg, rep_lat_reg} <= 3'h0;
			nak_code_reg <= ERR_NONE;
			rep_code_reg <= ERR_NONE;
			rep_kind_reg <= REPLY_WRITE;
			rep_data_reg <= '0;
		end else begin
			rung_reg <= rung_next;
			rung_prev_reg <= rung_reg;
			rsp_reg <= rsp_next;
			data_reg <= data_next;
			{en_reg, st_reg, dn_reg, er_reg} <= {en_next, st_next, dn_next, er_next};
			{ew_reg, nr_reg, to_reg} <= {ew_next, nr_next, to_next};
			code_reg <= code_next;
			phase_reg <= phase_next;
			{ack_lat_reg, nak_lat_reg, rep_lat_reg} <= {ack_lat_next, nak_lat_next, rep_lat_next};
			nak_code_reg <= nak_code_next;
			rep_code_reg <= rep_code_next;
			rep_kind_reg <= rep_kind_next;
			rep_data_reg <= rep_data_next;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			msg_send_out <= 1'b0;
			series_stat_out <= 1'b0;
			busy_out <= 1'b0;
			status_word_out <= 16'h0000;
			dest_wr_out <= '0;
		end else begin
			msg_send_out <= send_next;
			series_stat_out <= stat_next;
			busy_out <= st_next;
			status_word_out <= {en_next, st_next, dn_next, er_next, 1'b0, ew_next, nr_next,
				to_next, code_next};
			dest_wr_out <= dest_next;
		end
	end

	assign apb_rsp_out = rsp_reg;

	// ************
	// Assertions.
	// ************
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	a_rise_sets_wait: assert property (rung_rise && !to_wr |=> ew_reg && !st_reg && !dn_reg
		&& !nr_reg && !to_reg) else $error("Rung rise did not reset flags.");
	a_enable_needs_buf: assert property ($rose(en_reg) |-> $past(tx_buf_avail_in)
		&& $past(rung_reg)) else $error("Enable rose without buffer.");
	a_enable_holds: assert property (en_reg && !finished && !dn_next && !er_next && !to_next
		|=> en_reg) else $error("Enable dropped early.");
	a_timeout_ignored: assert property (to_reg && !st_reg && !end_of_scan_in && !rung_rise
		|=> er_reg == $past(er_reg)) else $error("Timeout acted while not started.");
	a_ack_starts: assert property (use_ack |=> st_reg && !ew_reg && busy_out)
		else $error("Acknowledge did not start transaction.");
	a_timeout_ends: assert property (to_kill |=> er_reg && !st_reg && code_reg == ERR_TIMEOUT
		&& !ack_lat_reg && !rep_lat_reg) else $error("Timeout did not end transaction.");
	a_nak_error: assert property (use_nak |=> er_reg && !ew_reg && !st_reg)
		else $error("Negative acknowledge not handled.");
	a_nr_cause: assert property ($rose(nr_reg) |-> $past(protocol_peer_in)
		&& $past(nak_code_reg) == ERR_BUSY) else $error("Negative response without busy.");
	a_read_stores: assert property (use_rep && rep_kind_reg == REPLY_READ |=> dest_wr_out.valid
		&& dn_reg && !st_reg) else $error("Read reply not stored.");
	a_enable_clears: assert property (end_of_scan_in && !rung_reg && finished |=> !en_reg)
		else $error("Enable not cleared after completion.");

	c_ack_flow: cover property (use_ack ##[1:50] use_rep);
	c_nak_flow: cover property (use_nak ##1 nr_reg);
	c_read_done: cover property (dest_wr_out.valid);
	c_timeout: cover property (to_kill);
endmodule
`default_nettype wire

// File: testbench/mtc_target_model.sv
`timescale 1ns/10ps
`default_nettype none
module mtc_target_model (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic send_in,
	input wire logic nak_in,
	input wire logic [7:0] code_in,
	input wire mtc_pkg::mtc_reply_t kind_in,
	input wire logic [15:0] data_in,
	input wire logic [9:0] reply_dly_in,
	output var mtc_pkg::mtc_net_evt_t evt_out
);
	import mtc_pkg::*;
	logic [9:0] cnt;
	logic [1:0] ph;
	initial evt_out = '0;
	// Released code and data fields change every cycle so stale data cannot pass as valid; reply_kind holds.
	always @(posedge clk_in) begin
		evt_out.ack <= 1'b0;
		evt_out.nak <= 1'b0;
		evt_out.reply <= 1'b0;
		evt_out.nak_code <= ~evt_out.nak_code;
		evt_out.reply_code <= ~evt_out.reply_code;
		evt_out.reply_data <= ~evt_out.reply_data;
		if (sys_rst_in) begin
			ph <= 2'h0;
			cnt <= 10'h000;
			evt_out <= '0;
		end else if (send_in) begin
			ph <= 2'h1;
			cnt <= 10'h006;
		end else if (cnt != 10'h000) begin
			cnt <= cnt - 10'h001;
		end else if (ph == 2'h1 && nak_in) begin
			evt_out.nak <= 1'b1;
			evt_out.nak_code <= code_in;
			ph <= 2'h0;
		end else if (ph == 2'h1) begin
			evt_out.ack <= 1'b1;
			ph <= 2'h2;
			cnt <= reply_dly_in;
		end else if (ph == 2'h2) begin
			evt_out.reply <= 1'b1;
			evt_out.reply_kind <= kind_in;
			evt_out.reply_code <= code_in;
			evt_out.reply_data <= data_in;
			ph <= 2'h0;
		end
	end
endmodule
`default_nettype wire

// File: testbench/mtc_message_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
module mtc_message_ctrl_test;
	import mtc_pkg::*;
	logic clk_in, rst, buf_free, eos, peer, send, series, busy, nak_m, e;
	mtc_apb_req_t req;
	mtc_apb_rsp_t rsp;
	mtc_net_evt_t evt;
	mtc_dest_wr_t dw;
	mtc_reply_t kind;
	logic [15:0] stw, rdat, dest_seen;
	logic [7:0] code;
	logic [9:0] rdly;
	logic [31:0] q;
	int bad_count, checks_done, cyc;
	mtc_message_ctrl i_mtc_message_ctrl (.clk_in(clk_in), .sys_rst_in(rst), .apb_req_in(req),
		.apb_rsp_out(rsp), .net_evt_in(evt), .tx_buf_avail_in(buf_free), .end_of_scan_in(eos),
		.protocol_peer_in(peer), .msg_send_out(send), .series_stat_out(series),
		.busy_out(busy), .status_word_out(stw), .dest_wr_out(dw));
	mtc_target_model i_mtc_target_model (.clk_in(clk_in), .sys_rst_in(rst), .send_in(send),
		.nak_in(nak_m), .code_in(code), .kind_in(kind), .data_in(rdat),
		.reply_dly_in(rdly), .evt_out(evt));
	initial clk_in = 1'b0;
	always #2 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		if (dw.valid === 1'b1) dest_seen <= dw.data;
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			results;
		end
	end
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
		@(posedge clk_in);
		req.penable <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		chk("pready", 32'h0000_0001, {31'h0, rsp.pready});
		q = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
	endtask
	task automatic rd(input logic [31:0] exp);
		apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk("status", exp, q);
	endtask
	task automatic scan;
		@(posedge clk_in);
		eos <= 1'b1;
		@(posedge clk_in);
		eos <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask
	task automatic go(input logic n, input logic [7:0] c, input mtc_reply_t k,
		input logic [15:0] d, input logic [9:0] dl);
		nak_m <= n;
		code <= c;
		kind <= k;
		rdat <= d;
		rdly <= dl;
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		repeat (16) @(posedge clk_in);
	endtask
	task automatic stop;
		apb(1'b1, OFS_CTRL, 32'h0000_0000);
		scan;
	endtask
	// Flags in order enable, started, done, error, waiting, negative-response, timeout.
	function automatic logic [31:0] st(input logic [6:0] f, input logic [7:0] c);
		return {16'h0000, f[6:3], 1'b0, f[2:0], c};
	endfunction
	initial begin
		{rst, buf_free, eos, peer, nak_m} = 5'b10000;
		{code, kind, rdat, rdly, dest_seen, req} = '0;
		bad_count = 0;
		checks_done = 0;
		cyc = 0;
		repeat (20) @(posedge clk_in);
		rst <= 1'b0;
		rd(st(7'b0000000, 8'h00));
		apb(1'b0, 12'h00C, 32'h0000_0000);
		chk("slverr", 32'h0000_0001, {31'h0, e});
		chk("unmapped", 32'h0000_0000, q);
		$display("test reset done");
		go(1'b0, 8'h00, REPLY_WRITE, 16'h0000, 10'h01E);
		rd(st(7'b0000100, 8'h00));
		buf_free <= 1'b1;
		repeat (14) @(posedge clk_in);
		chk("series", 32'h0000_0000, {31'h0, series});
		rd(st(7'b1000100, 8'h00));
		scan;
		rd(st(7'b1100000, 8'h00));
		chk("busy", 32'h0000_0001, {31'h0, busy});
		repeat (40) @(posedge clk_in);
		rd(st(7'b1100000, 8'h00));
		scan;
		rd(st(7'b1010000, 8'h00));
		stop;
		rd(st(7'b0010000, 8'h00));
		$display("test write done");
		go(1'b0, 8'h00, REPLY_READ, 16'hA5C3, 10'h01E);
		scan;
		repeat (40) @(posedge clk_in);
		scan;
		rd(st(7'b1010000, 8'h00));
		chk("dest", 32'h0000_A5C3, {16'h0000, dest_seen});
		apb(1'b0, OFS_DATA, 32'h0000_0000);
		chk("data", 32'h0000_A5C3, q);
		stop;
		go(1'b0, 8'h10, REPLY_ERROR, 16'h0000, 10'h01E);
		scan;
		repeat (40) @(posedge clk_in);
		scan;
		rd(st(7'b1001000, 8'h10));
		stop;
		$display("test read and error done");
		peer <= 1'b1;
		go(1'b1, 8'h02, REPLY_WRITE, 16'h0000, 10'h01E);
		scan;
		rd(st(7'b1001010, 8'h02));
		stop;
		buf_free <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		rd(st(7'b0000100, 8'h00));
		peer <= 1'b0;
		buf_free <= 1'b1;
		repeat (16) @(posedge clk_in);
		scan;
		rd(st(7'b1001000, 8'h02));
		stop;
		$display("test negative done");
		go(1'b0, 8'h00, REPLY_WRITE, 16'h0000, 10'h1F4);
		scan;
		repeat (300) @(posedge clk_in);
		chk("busy", 32'h0000_0001, {31'h0, busy});
		apb(1'b1, OFS_CTRL, 32'h0000_0003);
		repeat (2) @(posedge clk_in);
		rd(st(7'b1001001, 8'h37));
		chk("busy", 32'h0000_0000, {31'h0, busy});
		repeat (250) @(posedge clk_in);
		scan;
		rd(st(7'b1001001, 8'h37));
		stop;
		$display("test timeout done");
		results;
	end
endmodule
`default_nettype wire
